// file: verilog/fsc_regs.svh
`ifndef FSC_REGS_SVH
`define FSC_REGS_SVH
// ----------------------------------------
// bus side register map
// ----------------------------------------
`define FSC_OFS_CTRL    8'h00
`define FSC_OFS_ADDR    8'h04
`define FSC_OFS_STATUS  8'h08
`define FSC_CTRL_IRQEN  0
`define FSC_ADDR_RESET  7'h08
// ----------------------------------------
// link side constants
// ----------------------------------------
`define FSC_GCALL_ADDR  8'h00
`define FSC_GCALL_RST   8'h06
`define FSC_CMD_START_W 16'h3608
`define FSC_CMD_START_I 16'h3615
`define FSC_CMD_STOP    16'h3FF9
`define FSC_CRC_POLY    8'h31
`define FSC_CRC_INIT    8'hFF
`define FSC_FLAG_AIR    0
`define FSC_FLAG_HIGH   1
`define FSC_FLAG_SMOOTH 5
`define FSC_RD_BYTES    9
// ----------------------------------------
// timing
// ----------------------------------------
`define FSC_CLK_MHZ     100
`define FSC_WARM_US     12000
`define FSC_STOP_US     500
`endif

// file: verilog/fsc_pkg.sv
package fsc_pkg;
  typedef enum logic [2:0] {
    FSC_I_IDLE = 3'h0,
    FSC_I_ADDR = 3'h1,
    FSC_I_AACK = 3'h3,
    FSC_I_WR   = 3'h2,
    FSC_I_WACK = 3'h6,
    FSC_I_RD   = 3'h7,
    FSC_I_RACK = 3'h5
  } fsc_i2c_st_t;
  typedef enum logic [1:0] {
    FSC_M_IDLE = 2'h0,
    FSC_M_MEAS = 2'h1,
    FSC_M_STOP = 2'h3
  } fsc_mode_t;
endpackage : fsc_pkg

// file: verilog/fsc_i2c_cmd_if.sv
// Operation
// - when enabled, interrupt pin low while an unread result exists, else high.
// - interrupt returns high once the host reads the flow value.
// - interrupt pin stays inactive until software activates it.
// - respond to 7-bit address 8; header is address plus direction bit.
// - changed address reverts to default on hard or soft reset.
// - commands are write transfers of 16 bits, high byte first.
// - reads return 16-bit words, each followed by a checksum byte.
// - host may end a read with NACK and STOP; data line released.
// - 0x3608 starts water measurement, 0x3615 starts alcohol measurement.
// - start command selects which of two calibrations applies.
// - while measuring, each read header delivers the current result set.
// - first result readable 12 ms after start.
// - read header not acknowledged while no data exists.
// - read order: flow, CRC, temperature, CRC, flags, CRC.
// - flag bit 0 air-in-line, bit 1 high flow, bit 5 smoothing.
// - flag bits 2-4 and 6-15 are reserved.
// - CRC-8 over two bytes, poly 0x31, init 0xFF, no reflect or xor.
// - air and high-flow flags stay set until the flags word is read.
// - 0x3FF9 stops measurement, idle within 0.5 ms, then accepts commands.
// - while measuring, ignore all commands except stop and soft reset.
//
// The implementer's own choices: the register offsets and the Wishbone slave port.
`timescale 1ns/100ps
`include "fsc_regs.svh"
`default_nettype none
module fsc_i2c_cmd_if
  import fsc_pkg::*;
#(
  parameter int WARM_CYCLES = `FSC_WARM_US * `FSC_CLK_MHZ,
  parameter int STOP_CYCLES = `FSC_STOP_US * `FSC_CLK_MHZ
) (
  // clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        rstn_in,
  input  wire logic        ce_in,
  // wishbone slave
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  // i2c pins
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_out,
  output logic             new_data_irq_n_out,
  // measurement engine
  input  wire logic        meas_stb_in,
  input  wire logic [15:0] flow_in,
  input  wire logic [15:0] temp_in,
  input  wire logic        air_evt_in,
  input  wire logic        high_flow_evt_in,
  input  wire logic        smooth_in,
  output logic             heater_on_out,
  output logic             calib_ipa_out
);
  localparam int WW = $clog2(WARM_CYCLES + 1);
  localparam int SW = $clog2(STOP_CYCLES + 1);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
    c = `FSC_CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      if (c[7] ^ d[i]) begin
        c = {c[6:0], 1'b0} ^ `FSC_CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    return c;
  endfunction : crc8

  function automatic logic [7:0] rd_byte(input logic [3:0] i,
      input logic [15:0] f, input logic [15:0] t, input logic [15:0] g);
    case (i)
      4'h0: rd_byte = f[15:8];
      4'h1: rd_byte = f[7:0];
      4'h2: rd_byte = crc8(f);
      4'h3: rd_byte = t[15:8];
      4'h4: rd_byte = t[7:0];
      4'h5: rd_byte = crc8(t);
      4'h6: rd_byte = g[15:8];
      4'h7: rd_byte = g[7:0];
      4'h8: rd_byte = crc8(g);
      default: rd_byte = 8'hFF;
    endcase
  endfunction : rd_byte

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic       scl_d_reg;
  logic       sda_d_reg;
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_d_reg    <= 1'b1;
      sda_d_reg    <= 1'b1;
    end else if (ce_in) begin
      scl_sync_reg <= {scl_sync_reg[0], scl_in};
      sda_sync_reg <= {sda_sync_reg[0], sda_in};
      scl_d_reg    <= scl_sync_reg[1];
      sda_d_reg    <= sda_sync_reg[1];
    end
  end
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  assign scl_s     = scl_sync_reg[1];
  assign sda_s     = sda_sync_reg[1];
  assign scl_rise  = scl_s & ~scl_d_reg;
  assign scl_fall  = ~scl_s & scl_d_reg;
  assign bus_start = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign bus_stop  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  // ----------------------------------------
  // shared state
  // ----------------------------------------
  fsc_i2c_st_t st_reg;
  fsc_mode_t   mode_reg;
  logic [3:0]  cnt_reg;
  logic [3:0]  idx_reg;
  logic [7:0]  sh_reg;
  logic [7:0]  tx_reg;
  logic        oe_reg;
  logic        rd_reg;
  logic        gc_reg;
  logic        hack_reg;
  logic        cmd_stb_reg;
  logic [15:0] cmd_reg;
  logic        srst_reg;
  logic        snap_stb_reg;
  logic        flag_ld_reg;
  logic [6:0]  addr_reg;
  logic        irq_en_reg;
  logic        has_data_reg;
  logic        new_reg;
  logic        calib_reg;
  logic [15:0] flow_reg;
  logic [15:0] temp_reg;
  logic [15:0] flow_snap_reg;
  logic [15:0] temp_snap_reg;
  logic [15:0] flag_snap_reg;
  logic        air_reg;
  logic        high_reg;
  logic        smooth_reg;
  logic [WW-1:0] warm_cnt_reg;
  logic [SW-1:0] stop_cnt_reg;
  logic        wr_ok;
  logic [15:0] flags_now;
  logic [15:0] flags_tx;
  logic [7:0]  nxt_byte;
  assign wr_ok = (mode_reg != FSC_M_STOP);
  // reserved positions forced to zero
  always_comb begin
    flags_now = 16'h0000;
    flags_now[`FSC_FLAG_AIR]    = air_reg | air_evt_in;
    flags_now[`FSC_FLAG_HIGH]   = high_reg | high_flow_evt_in;
    flags_now[`FSC_FLAG_SMOOTH] = smooth_reg;
  end
  // sticky bits clear at the high byte, so the low byte needs the latch
  assign flags_tx = (idx_reg == 4'h5) ? flags_now : flag_snap_reg;
  assign nxt_byte = rd_byte(idx_reg + 4'h1, flow_snap_reg, temp_snap_reg,
                            flags_tx);

  // ----------------------------------------
  // i2c target
  // ----------------------------------------
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_reg       <= FSC_I_IDLE;
      cnt_reg      <= 4'h0;
      idx_reg      <= 4'h0;
      sh_reg       <= 8'h00;
      tx_reg       <= 8'h00;
      oe_reg       <= 1'b0;
      rd_reg       <= 1'b0;
      gc_reg       <= 1'b0;
      hack_reg     <= 1'b0;
      cmd_stb_reg  <= 1'b0;
      cmd_reg      <= 16'h0000;
      srst_reg     <= 1'b0;
      snap_stb_reg <= 1'b0;
      flag_ld_reg  <= 1'b0;
    end else if (ce_in) begin
      cmd_stb_reg  <= 1'b0;
      srst_reg     <= 1'b0;
      snap_stb_reg <= 1'b0;
      flag_ld_reg  <= 1'b0;
      if (bus_start) begin
        st_reg  <= FSC_I_ADDR;
        cnt_reg <= 4'h0;
        oe_reg  <= 1'b0;
      end else if (bus_stop || srst_reg) begin
        st_reg <= FSC_I_IDLE;
        oe_reg <= 1'b0;
      end else begin
        case (st_reg)
          FSC_I_ADDR: begin
            if (scl_rise) begin
              sh_reg  <= {sh_reg[6:0], sda_s};
              cnt_reg <= cnt_reg + 4'h1;
            end else if (scl_fall && cnt_reg == 4'h8) begin
              idx_reg <= 4'h0;
              rd_reg  <= sh_reg[0];
              gc_reg  <= (sh_reg == `FSC_GCALL_ADDR);
              if (sh_reg == `FSC_GCALL_ADDR ||
                  (sh_reg[7:1] == addr_reg && !sh_reg[0] && wr_ok)) begin
                st_reg <= FSC_I_AACK;
                oe_reg <= 1'b1;
              end else if (sh_reg[7:1] == addr_reg && sh_reg[0] &&
                           has_data_reg) begin
                st_reg       <= FSC_I_AACK;
                oe_reg       <= 1'b1;
                snap_stb_reg <= 1'b1;
              end else begin
                st_reg <= FSC_I_IDLE;
              end
            end
          end
          FSC_I_AACK: begin
            if (scl_fall) begin
              cnt_reg <= 4'h0;
              if (rd_reg) begin
                st_reg <= FSC_I_RD;
                tx_reg <= rd_byte(4'h0, flow_snap_reg, temp_snap_reg,
                                  flag_snap_reg);
                oe_reg <= ~flow_snap_reg[15];
              end else begin
                st_reg <= FSC_I_WR;
                oe_reg <= 1'b0;
              end
            end
          end
          FSC_I_WR: begin
            if (scl_rise) begin
              sh_reg  <= {sh_reg[6:0], sda_s};
              cnt_reg <= cnt_reg + 4'h1;
            end else if (scl_fall && cnt_reg == 4'h8) begin
              if (gc_reg) begin
                st_reg   <= FSC_I_WACK;
                oe_reg   <= (sh_reg == `FSC_GCALL_RST);
              end else if (idx_reg < 4'h2) begin
                cmd_reg     <= {cmd_reg[7:0], sh_reg};
                cmd_stb_reg <= (idx_reg == 4'h1);
                st_reg      <= FSC_I_WACK;
                oe_reg      <= 1'b1;
              end else begin
                st_reg <= FSC_I_IDLE;
              end
            end
          end
          FSC_I_WACK: begin
            if (scl_fall) begin
              // reset only after its ack bit has been clocked out
              srst_reg <= gc_reg && (sh_reg == `FSC_GCALL_RST);
              st_reg  <= FSC_I_WR;
              oe_reg  <= 1'b0;
              cnt_reg <= 4'h0;
              idx_reg <= idx_reg + 4'h1;
            end
          end
          FSC_I_RD: begin
            if (scl_rise) begin
              cnt_reg <= cnt_reg + 4'h1;
            end else if (scl_fall) begin
              if (cnt_reg == 4'h8) begin
                st_reg <= FSC_I_RACK;
                oe_reg <= 1'b0;
              end else begin
                tx_reg <= {tx_reg[6:0], 1'b0};
                oe_reg <= ~tx_reg[6];
              end
            end
          end
          FSC_I_RACK: begin
            if (scl_rise) begin
              hack_reg <= ~sda_s;
            end else if (scl_fall) begin
              cnt_reg <= 4'h0;
              if (hack_reg && idx_reg < 4'(`FSC_RD_BYTES - 1)) begin
                st_reg  <= FSC_I_RD;
                idx_reg <= idx_reg + 4'h1;
                tx_reg  <= nxt_byte;
                oe_reg  <= ~nxt_byte[7];
                flag_ld_reg <= (idx_reg == 4'h5);
              end else begin
                st_reg <= FSC_I_IDLE;
                oe_reg <= 1'b0;
              end
            end
          end
          default: begin
            st_reg <= FSC_I_IDLE;
            oe_reg <= 1'b0;
          end
        endcase
      end
    end
  end
  assign sda_out    = 1'b0;
  assign sda_oe_out = oe_reg;

  // ----------------------------------------
  // measurement control
  // ----------------------------------------
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mode_reg     <= FSC_M_IDLE;
      calib_reg    <= 1'b0;
      warm_cnt_reg <= '0;
      stop_cnt_reg <= '0;
    end else if (ce_in) begin
      if (srst_reg) begin
        mode_reg <= FSC_M_IDLE;
      end else begin
        case (mode_reg)
          FSC_M_IDLE: begin
            warm_cnt_reg <= '0;
            if (cmd_stb_reg && cmd_reg == `FSC_CMD_START_W) begin
              mode_reg  <= FSC_M_MEAS;
              calib_reg <= 1'b0;
            end else if (cmd_stb_reg && cmd_reg == `FSC_CMD_START_I) begin
              mode_reg  <= FSC_M_MEAS;
              calib_reg <= 1'b1;
            end
          end
          FSC_M_MEAS: begin
            if (!has_data_reg) begin
              warm_cnt_reg <= warm_cnt_reg + WW'(1);
            end
            stop_cnt_reg <= '0;
            if (cmd_stb_reg && cmd_reg == `FSC_CMD_STOP) begin
              mode_reg <= FSC_M_STOP;
            end
          end
          FSC_M_STOP: begin
            stop_cnt_reg <= stop_cnt_reg + SW'(1);
            if (stop_cnt_reg == SW'(STOP_CYCLES - 1)) begin
              mode_reg <= FSC_M_IDLE;
            end
          end
          default: mode_reg <= FSC_M_IDLE;
        endcase
      end
    end
  end
  assign heater_on_out = (mode_reg == FSC_M_MEAS);
  assign calib_ipa_out = calib_reg;

  // ----------------------------------------
  // results, flags and new-data
  // ----------------------------------------
  logic warm_done;
  assign warm_done = (mode_reg == FSC_M_MEAS) && !has_data_reg &&
                     (warm_cnt_reg == WW'(WARM_CYCLES - 1));
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      has_data_reg  <= 1'b0;
      new_reg       <= 1'b0;
      flow_reg      <= 16'h0000;
      temp_reg      <= 16'h0000;
      flow_snap_reg <= 16'h0000;
      temp_snap_reg <= 16'h0000;
      flag_snap_reg <= 16'h0000;
      air_reg       <= 1'b0;
      high_reg      <= 1'b0;
      smooth_reg    <= 1'b0;
    end else if (ce_in) begin
      if (mode_reg != FSC_M_MEAS || srst_reg) begin
        has_data_reg <= 1'b0;
      end else if (warm_done) begin
        has_data_reg <= 1'b1;
      end
      if (mode_reg == FSC_M_MEAS && meas_stb_in) begin
        flow_reg   <= flow_in;
        temp_reg   <= temp_in;
        smooth_reg <= smooth_in;
      end
      // new result wins over a same-cycle readout
      if ((meas_stb_in && has_data_reg) || warm_done) begin
        new_reg <= 1'b1;
      end else if (snap_stb_reg || mode_reg != FSC_M_MEAS) begin
        new_reg <= 1'b0;
      end
      if (snap_stb_reg) begin
        flow_snap_reg <= flow_reg;
        temp_snap_reg <= temp_reg;
      end
      if (flag_ld_reg) begin
        flag_snap_reg <= flags_now;
        air_reg       <= air_evt_in;
        high_reg      <= high_flow_evt_in;
      end else if (mode_reg == FSC_M_MEAS) begin
        air_reg  <= air_reg | air_evt_in;
        high_reg <= high_reg | high_flow_evt_in;
      end
    end
  end
  assign new_data_irq_n_out = ~(irq_en_reg & new_reg);

  // ----------------------------------------
  // wishbone registers
  // ----------------------------------------
  logic wb_req;
  assign wb_req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h00000000;
      addr_reg   <= `FSC_ADDR_RESET;
      irq_en_reg <= 1'b0;
    end else if (ce_in) begin
      wb_ack_out <= wb_req;
      wb_dat_out <= 32'h00000000;
      if (srst_reg) begin
        addr_reg   <= `FSC_ADDR_RESET;
        irq_en_reg <= 1'b0;
      end else if (wb_req && wb_we_in && wb_sel_in[0]) begin
        if (wb_adr_in == `FSC_OFS_CTRL) begin
          irq_en_reg <= wb_dat_in[`FSC_CTRL_IRQEN];
        end else if (wb_adr_in == `FSC_OFS_ADDR) begin
          addr_reg <= wb_dat_in[6:0];
        end
      end
      if (wb_req && !wb_we_in) begin
        if (wb_adr_in == `FSC_OFS_CTRL) begin
          wb_dat_out <= {31'h0, irq_en_reg};
        end else if (wb_adr_in == `FSC_OFS_ADDR) begin
          wb_dat_out <= {25'h0, addr_reg};
        end else if (wb_adr_in == `FSC_OFS_STATUS) begin
          wb_dat_out <= {27'h0, new_reg, has_data_reg, calib_reg,
                         mode_reg};
        end
      end
    end
  end
endmodule : fsc_i2c_cmd_if
`default_nettype wire

// file: bench/fsc_i2c_cmd_if_properties.sv
`timescale 1ns/100ps
`default_nettype none
`include "fsc_regs.svh"
// ----------------------------------------
// port checks
// ----------------------------------------
module fsc_cmd_props (
  // clock and reset
  input wire logic        sys_clk_in,
  input wire logic        rstn_in,
  input wire logic        ce_in,
  // wishbone
  input wire logic        wb_cyc_in,
  input wire logic        wb_stb_in,
  input wire logic        wb_we_in,
  input wire logic [7:0]  wb_adr_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic        wb_ack_out,
  // link and status
  input wire logic        scl_in,
  input wire logic        sda_in,
  input wire logic        sda_oe_out,
  input wire logic        new_data_irq_n_out,
  input wire logic        heater_on_out,
  input wire logic        calib_ipa_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  chk_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack held past one cycle");
  chk_ack_timing: assert property (ce_in && wb_cyc_in && wb_stb_in &&
    !wb_ack_out |=> wb_ack_out) else $error("ack not one cycle late");
  chk_dat_idle: assert property (!wb_ack_out |-> wb_dat_out == 32'h0)
    else $error("read data outside ack");
  chk_unmapped_zero: assert property (wb_ack_out && !$past(wb_we_in) &&
    $past(wb_adr_in) > `FSC_OFS_STATUS |-> wb_dat_out == 32'h0)
    else $error("unmapped read not zero");
  chk_status_mode: assert property (wb_ack_out && !$past(wb_we_in) &&
    $past(wb_adr_in) == `FSC_OFS_STATUS |->
    ((wb_dat_out[1:0] == 2'h1) == $past(heater_on_out)) &&
    (wb_dat_out[2] == $past(calib_ipa_out)))
    else $error("status mode mismatch");
  chk_irq_unread: assert property (wb_ack_out && !$past(wb_we_in) &&
    $past(wb_adr_in) == `FSC_OFS_STATUS && !$past(new_data_irq_n_out)
    |-> wb_dat_out[4]) else $error("irq low without unread result");
  chk_stop_release: assert property ($rose(sda_in) && scl_in
    |-> ##4 !sda_oe_out) else $error("data line held after stop");
  chk_calib_hold: assert property ($changed(calib_ipa_out) &&
    heater_on_out |-> $rose(heater_on_out))
    else $error("calibration changed while measuring");
endmodule : fsc_cmd_props
bind fsc_i2c_cmd_if fsc_cmd_props fsc_cmd_props_inst (.sys_clk_in,
  .rstn_in, .ce_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in,
  .wb_dat_out, .wb_ack_out, .scl_in, .sda_in, .sda_oe_out,
  .new_data_irq_n_out, .heater_on_out, .calib_ipa_out);
`default_nettype wire

// file: bench/fsc_i2c_host.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// bus controller model, 160 ns bit period
// ----------------------------------------
module fsc_i2c_host (
  // clock
  input  wire logic clk_in,
  // link
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_oe_out
);
  initial begin
    scl_out = 1'b1;
    sda_oe_out = 1'b0;
  end
  task automatic q(input int n);
    repeat (n) @(posedge clk_in);
  endtask : q
  // data changes only mid low phase, never near the clock edges
  task automatic clk_bit(input logic b, output logic s);
    sda_oe_out <= !b;
    q(4);
    scl_out <= 1'b1;
    q(4);
    s = sda_in;
    q(4);
    scl_out <= 1'b0;
    q(4);
  endtask : clk_bit
  task automatic start();
    sda_oe_out <= 1'b1;
    q(8);
    scl_out <= 1'b0;
    q(4);
  endtask : start
  task automatic stop();
    sda_oe_out <= 1'b1;
    q(4);
    scl_out <= 1'b1;
    q(4);
    sda_oe_out <= 1'b0;
    q(8);
  endtask : stop
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
    clk_bit(1'b1, s);
    ack = !s;
  endtask : wbyte
  // last byte gets a nack, so a read may end after any byte
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, s);
      d[i] = s;
    end
    clk_bit(last, s);
  endtask : rbyte
endmodule : fsc_i2c_host
`default_nettype wire

// file: bench/fsc_i2c_cmd_if_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "fsc_regs.svh"
module fsc_i2c_cmd_if_tb_top;
  localparam int WARM = 400;
  localparam int STOPC = 20;
  logic             sys_clk_in = 1'b0;
  logic             rstn_in = 1'b0;
  logic             cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0]       sel = 4'h0;
  logic [7:0]       adr = 8'h00;
  logic [31:0]      wdat = 32'h0;
  logic             mstb = 1'b0, air = 1'b0, hi = 1'b0, sm = 1'b0;
  logic [15:0]      flow = 16'h0, temp = 16'h0;
  wire logic [31:0] rdat;
  wire logic        ack, scl, h_oe, d_oe, d_sda, irq_n, heat, calib;
  // pull-up: either party pulling low wins
  wire logic        sda = !(h_oe || (d_oe && !d_sda));
  int               error_cnt = 0;
  int               checked = 0;
  always #5 sys_clk_in = ~sys_clk_in;
  fsc_i2c_cmd_if #(.WARM_CYCLES(WARM), .STOP_CYCLES(STOPC))
    fsc_i2c_cmd_if_inst (.sys_clk_in, .rstn_in, .ce_in(1'b1),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
    .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
    .scl_in(scl), .sda_in(sda), .sda_out(d_sda), .sda_oe_out(d_oe),
    .new_data_irq_n_out(irq_n), .meas_stb_in(mstb), .flow_in(flow),
    .temp_in(temp), .air_evt_in(air), .high_flow_evt_in(hi),
    .smooth_in(sm), .heater_on_out(heat), .calib_ipa_out(calib));
  fsc_i2c_host host_inst (.clk_in(sys_clk_in), .sda_in(sda), .scl_out(scl),
    .sda_oe_out(h_oe));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic close_out();
    if (error_cnt == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] g, e, input string m);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk
  function automatic logic [7:0] crc(input logic [15:0] d);
    logic [7:0] c = 8'hFF;
    for (int i = 15; i >= 0; i--)
      c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ 8'h31) : {c[6:0], 1'b0};
    return c;
  endfunction : crc
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    int n = 0;
    @(posedge sys_clk_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (ack !== 1'b1 && n < 100);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 100) chk(1'b0, 1'b1, "bus answer");
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    wb(1'b0, a, 32'h0, r);
    chk(r, e, "register read");
  endtask : rd
  task automatic cmd(input logic [7:0] a, input logic [15:0] c,
                     input logic [2:0] e);
    logic [2:0] k;
    host_inst.start();
    host_inst.wbyte(a, k[2]);
    host_inst.wbyte(c[15:8], k[1]);
    host_inst.wbyte(c[7:0], k[0]);
    host_inst.stop();
    chk(k, e, "command acks");
  endtask : cmd
  task automatic rdm(input int n, input logic ex, input logic [15:0] f, t, g);
    logic        a;
    logic [7:0]  b;
    logic [71:0] e;
    e = {f, crc(f), t, crc(t), g, crc(g)};
    host_inst.start();
    host_inst.wbyte({7'h08, 1'b1}, a);
    chk(a, ex, "read header ack");
    for (int i = 0; i < n && a; i++) begin
      host_inst.rbyte(i == n - 1, b);
      chk(b, e[71 - 8 * i -: 8], "read byte");
    end
    host_inst.stop();
  endtask : rdm
  task automatic smp(input logic [15:0] f, t, input logic a, h, s);
    @(posedge sys_clk_in);
    mstb <= 1'b1;
    flow <= f;
    temp <= t;
    air <= a;
    hi <= h;
    sm <= s;
    @(posedge sys_clk_in);
    mstb <= 1'b0;
    air <= 1'b0;
    hi <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
  endtask : smp
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    logic [15:0] f, t;
    logic        s, h;
    logic [31:0] r;
    logic        k;
    void'($urandom(61));
    repeat (8) @(posedge sys_clk_in);
    rstn_in <= 1'b1;
    repeat (4) @(posedge sys_clk_in);
    chk(irq_n, 1'b1, "irq after reset");
    rd(`FSC_OFS_CTRL, 32'h0);
    rd(`FSC_OFS_ADDR, 32'h08);
    rd(8'h0C, 32'h0);
    rdm(3, 1'b0, 16'h0, 16'h0, 16'h0);
    cmd(8'h10, 16'h1234, 3'b111);
    cmd(8'h12, `FSC_CMD_START_I, 3'b000);
    chk(heat, 1'b0, "no start on foreign address");
    cmd(8'h10, `FSC_CMD_START_I, 3'b111);
    chk({heat, calib}, 2'b11, "alcohol start");
    rdm(1, 1'b0, 16'h0, 16'h0, 16'h0);
    repeat (WARM) @(posedge sys_clk_in);
    chk(irq_n, 1'b1, "irq inactive before activation");
    wb(1'b1, `FSC_OFS_CTRL, 32'h1, r);
    repeat (2) @(posedge sys_clk_in);
    chk(irq_n, 1'b0, "irq on first result");
    rd(`FSC_OFS_STATUS, 32'h1D);
    for (int i = 0; i < 3; i++) begin
      f = 16'($urandom);
      t = 16'($urandom);
      s = 1'($urandom);
      h = 1'($urandom);
      smp(f, t, 1'b1, h, s);
      chk(irq_n, 1'b0, "irq on new result");
      rdm(9, 1'b1, f, t, {10'h0, s, 3'h0, h, 1'b1});
      chk(irq_n, 1'b1, "irq cleared by read");
    end
    rdm(9, 1'b1, f, t, {10'h0, s, 5'h0});
    smp(16'hBEEF, 16'h8000, 1'b0, 1'b1, 1'b0);
    rdm(2, 1'b1, 16'hBEEF, 16'h0, 16'h0);
    chk(irq_n, 1'b1, "irq cleared by short read");
    cmd(8'h10, `FSC_CMD_START_W, 3'b111);
    cmd(8'h10, 16'h0000, 3'b111);
    chk({heat, calib}, 2'b11, "start ignored while measuring");
    cmd(8'h10, `FSC_CMD_STOP, 3'b111);
    chk(heat, 1'b0, "stopped");
    rdm(1, 1'b0, 16'h0, 16'h0, 16'h0);
    repeat (2 * STOPC) @(posedge sys_clk_in);
    rd(`FSC_OFS_STATUS, 32'h04);
    cmd(8'h10, `FSC_CMD_START_W, 3'b111);
    chk({heat, calib}, 2'b10, "water start");
    cmd(8'h10, `FSC_CMD_STOP, 3'b111);
    repeat (2 * STOPC) @(posedge sys_clk_in);
    wb(1'b1, `FSC_OFS_ADDR, 32'h21, r);
    cmd(8'h42, 16'h1234, 3'b111);
    cmd(8'h10, 16'h1234, 3'b000);
    host_inst.start();
    host_inst.wbyte(`FSC_GCALL_ADDR, k);
    chk(k, 1'b1, "general call ack");
    host_inst.wbyte(`FSC_GCALL_RST, k);
    chk(k, 1'b1, "soft reset ack");
    host_inst.stop();
    rd(`FSC_OFS_ADDR, 32'h08);
    rd(`FSC_OFS_CTRL, 32'h0);
    cmd(8'h10, 16'h1234, 3'b111);
    close_out();
  end
  initial begin
    #500000;
    error_cnt++;
    close_out();
  end
endmodule : fsc_i2c_cmd_if_tb_top
`default_nettype wire
